// file: shared/eth_dma_status_pkg.sv
// constants of the dma status and progress register block
// assumes an apb slave on a 32-bit bus clocked by pclk
package eth_dma_status_pkg;
    // ==========================================
    // register offsets
    localparam logic [12:0] DROP_COUNTS_OFFSET    = 13'h1020;
    localparam logic [12:0] TX_DESC_OFFSET        = 13'h1048;
    localparam logic [12:0] RX_DESC_OFFSET        = 13'h104C;
    localparam logic [12:0] TX_BUF_OFFSET         = 13'h1050;
    localparam logic [12:0] RX_BUF_OFFSET         = 13'h1054;
    localparam logic [12:0] IRQ_STATUS_OFFSET     = 13'h1100;
    localparam logic [12:0] IRQ_MASK_OFFSET       = 13'h1104;
    // ==========================================
    // field layout of the counter register
    localparam int NO_BUF_CNT_LSB   = 0;
    localparam int NO_BUF_CNT_W     = 16;
    localparam int NO_BUF_WRAP_BIT  = 16;
    localparam int FIFO_CNT_LSB     = 17;
    localparam int FIFO_CNT_W       = 11;
    localparam int FIFO_WRAP_BIT    = 28;
    // ==========================================
    // interrupt status bits
    localparam int IRQ_W            = 4;
    localparam int IRQ_NO_BUF_DROP  = 0;
    localparam int IRQ_FIFO_DROP    = 1;
    localparam int IRQ_NO_BUF_WRAP  = 2;
    localparam int IRQ_FIFO_WRAP    = 3;
    // ==========================================
    // reset values
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
endpackage

// file: design/drop_counter.sv
// one wrapping drop counter with sticky wrap flag
// assumes event and clear come from pclk logic
`timescale 1ns/1ns
`default_nettype none
module drop_counter #(
    parameter int WIDTH = 16
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             drop_event,
    input  wire logic             clear,
    output logic      [WIDTH-1:0] count,
    output logic                  wrap_flag,
    output logic                  wrapped
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic             wrap_flag;
    } state_type;

    state_type state_q;
    state_type state_d;

    always_comb begin
        state_d = state_q;
        // a drop in the clearing cycle starts from zero, so it never wraps
        wrapped = drop_event && !clear && (&state_q.count);
        if (clear) begin
            state_d.count     = '0;
            state_d.wrap_flag = 1'b0;
        end
        // an event in the clearing cycle is counted after the clear
        if (drop_event) begin
            if (clear) begin
                state_d.count = WIDTH'(1);
            end else begin
                state_d.count = state_q.count + WIDTH'(1);
            end
            if (wrapped) begin
                state_d.wrap_flag = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign count     = state_q.count;
    assign wrap_flag = state_q.wrap_flag;
endmodule
`default_nettype wire

// file: design/eth_dma_status.sv
// dma status and progress registers behind an apb slave
// assumes dma engine strobes and pointers arrive on pclk
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module eth_dma_status (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [12:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        no_buffer_drop,
    input  wire logic        fifo_overflow_drop,
    input  wire logic        tx_desc_load,
    input  wire logic [31:0] tx_desc_addr,
    input  wire logic        rx_desc_load,
    input  wire logic [31:0] rx_desc_addr,
    input  wire logic        tx_buf_load,
    input  wire logic [31:0] tx_buf_addr,
    input  wire logic        rx_buf_load,
    input  wire logic [31:0] rx_buf_addr,
    output logic             irq
);
    // ==========================================
    // state
    // one-hot phase of the bus slave; every access takes one wait state
    typedef enum logic [2:0] {
        BUS_IDLE    = 3'b001,
        BUS_CAPTURE = 3'b010,
        BUS_DONE    = 3'b100
    } bus_phase_type;

    typedef struct packed {
        bus_phase_type                             bus_phase;
        logic [31:0]                               cur_tx_desc_addr;
        logic [31:0]                               cur_rx_desc_addr;
        logic [31:0]                               cur_tx_buf_addr;
        logic [31:0]                               cur_rx_buf_addr;
        logic [eth_dma_status_pkg::IRQ_W-1:0]      irq_status;
        logic [eth_dma_status_pkg::IRQ_W-1:0]      irq_mask;
        logic [31:0]                               rdata;
    } state_type;

    state_type state_q;
    state_type state_d;

    logic                                        rd_access;
    logic                                        wr_access;
    logic                                        counts_read;
    logic                                        status_read;
    logic                                        capture;
    logic                                        mapped;
    logic [eth_dma_status_pkg::NO_BUF_CNT_W-1:0] no_buffer_drop_count;
    logic [eth_dma_status_pkg::FIFO_CNT_W-1:0]   fifo_overflow_drop_count;
    logic                                        no_buffer_drop_wrap_flag;
    logic                                        fifo_overflow_drop_wrap_flag;
    logic                                        no_buf_wrapped;
    logic                                        fifo_wrapped;
    logic [31:0]                                 counts_word;
    logic [eth_dma_status_pkg::IRQ_W-1:0]        irq_events;

    // ==========================================
    // apb decode; read data comes from a register, so pready waits one cycle
    assign capture   = psel && penable && (state_q.bus_phase == BUS_CAPTURE);
    assign pready    = (state_q.bus_phase == BUS_DONE);
    // read side effects go with the capture, so no drop slips between
    assign rd_access = capture && !pwrite;
    assign wr_access = psel && penable && pready && pwrite;

    always_comb begin
        case (paddr)
            eth_dma_status_pkg::DROP_COUNTS_OFFSET,
            eth_dma_status_pkg::TX_DESC_OFFSET,
            eth_dma_status_pkg::RX_DESC_OFFSET,
            eth_dma_status_pkg::TX_BUF_OFFSET,
            eth_dma_status_pkg::RX_BUF_OFFSET,
            eth_dma_status_pkg::IRQ_STATUS_OFFSET,
            eth_dma_status_pkg::IRQ_MASK_OFFSET: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign pslverr     = psel && penable && pready && !mapped;
    assign counts_read = rd_access && (paddr == eth_dma_status_pkg::DROP_COUNTS_OFFSET);
    assign status_read = rd_access && (paddr == eth_dma_status_pkg::IRQ_STATUS_OFFSET);

    // ==========================================
    // drop counters; a read of the counter register clears them
    drop_counter #(
        .WIDTH (eth_dma_status_pkg::NO_BUF_CNT_W)
    ) no_buffer_counter (
        .pclk       (pclk),
        .presetn    (presetn),
        .drop_event (no_buffer_drop),
        .clear      (counts_read),
        .count      (no_buffer_drop_count),
        .wrap_flag  (no_buffer_drop_wrap_flag),
        .wrapped    (no_buf_wrapped)
    );

    drop_counter #(
        .WIDTH (eth_dma_status_pkg::FIFO_CNT_W)
    ) fifo_overflow_counter (
        .pclk       (pclk),
        .presetn    (presetn),
        .drop_event (fifo_overflow_drop),
        .clear      (counts_read),
        .count      (fifo_overflow_drop_count),
        .wrap_flag  (fifo_overflow_drop_wrap_flag),
        .wrapped    (fifo_wrapped)
    );

    always_comb begin
        counts_word = eth_dma_status_pkg::REG_RESET;
        counts_word[eth_dma_status_pkg::NO_BUF_CNT_LSB +: eth_dma_status_pkg::NO_BUF_CNT_W]
            = no_buffer_drop_count;
        counts_word[eth_dma_status_pkg::NO_BUF_WRAP_BIT] = no_buffer_drop_wrap_flag;
        counts_word[eth_dma_status_pkg::FIFO_CNT_LSB +: eth_dma_status_pkg::FIFO_CNT_W]
            = fifo_overflow_drop_count;
        counts_word[eth_dma_status_pkg::FIFO_WRAP_BIT] = fifo_overflow_drop_wrap_flag;
    end

    always_comb begin
        irq_events = '0;
        irq_events[eth_dma_status_pkg::IRQ_NO_BUF_DROP] = no_buffer_drop;
        irq_events[eth_dma_status_pkg::IRQ_FIFO_DROP]   = fifo_overflow_drop;
        irq_events[eth_dma_status_pkg::IRQ_NO_BUF_WRAP] = no_buf_wrapped;
        irq_events[eth_dma_status_pkg::IRQ_FIFO_WRAP]   = fifo_wrapped;
    end

    // ==========================================
    // next state
    always_comb begin
        state_d = state_q;
        // a setup always starts a new transfer
        case (state_q.bus_phase)
            BUS_IDLE: begin
                if (psel && !penable) begin
                    state_d.bus_phase = BUS_CAPTURE;
                end
            end
            BUS_CAPTURE: begin
                if (psel && penable) begin
                    state_d.bus_phase = BUS_DONE;
                end else if (!psel) begin
                    state_d.bus_phase = BUS_IDLE;
                end
            end
            BUS_DONE: begin
                state_d.bus_phase = BUS_IDLE;
            end
            default: begin
                state_d.bus_phase = BUS_IDLE;
            end
        endcase
        // read data stands only in the cycle in which pready is high
        state_d.rdata = 32'h0000_0000;
        // pointers follow the dma engine only; bus writes never reach them
        if (tx_desc_load) begin
            state_d.cur_tx_desc_addr = tx_desc_addr;
        end
        if (rx_desc_load) begin
            state_d.cur_rx_desc_addr = rx_desc_addr;
        end
        if (tx_buf_load) begin
            state_d.cur_tx_buf_addr = tx_buf_addr;
        end
        if (rx_buf_load) begin
            state_d.cur_rx_buf_addr = rx_buf_addr;
        end
        // new events win over the read that clears status
        if (status_read) begin
            state_d.irq_status = irq_events;
        end else begin
            state_d.irq_status = state_q.irq_status | irq_events;
        end
        if (wr_access && (paddr == eth_dma_status_pkg::IRQ_MASK_OFFSET) && pstrb[0]) begin
            state_d.irq_mask = pwdata[eth_dma_status_pkg::IRQ_W-1:0];
        end
        if (rd_access) begin
            case (paddr)
                eth_dma_status_pkg::DROP_COUNTS_OFFSET: state_d.rdata = counts_word;
                eth_dma_status_pkg::TX_DESC_OFFSET:     state_d.rdata = state_q.cur_tx_desc_addr;
                eth_dma_status_pkg::RX_DESC_OFFSET:     state_d.rdata = state_q.cur_rx_desc_addr;
                eth_dma_status_pkg::TX_BUF_OFFSET:      state_d.rdata = state_q.cur_tx_buf_addr;
                eth_dma_status_pkg::RX_BUF_OFFSET:      state_d.rdata = state_q.cur_rx_buf_addr;
                eth_dma_status_pkg::IRQ_STATUS_OFFSET:
                    state_d.rdata = {28'h0000000, state_q.irq_status};
                eth_dma_status_pkg::IRQ_MASK_OFFSET:
                    state_d.rdata = {28'h0000000, state_q.irq_mask};
                default:                                state_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= '{bus_phase: BUS_IDLE, default: '0};
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================
    // read data straight from its register; zero outside a finished read
    assign prdata = state_q.rdata;

    assign irq = |(state_q.irq_status & state_q.irq_mask);
endmodule
`default_nettype wire

// file: tb/eth_dma_status_monitor.sv
// port checker for the dma status register block
// assumes it is bound to eth_dma_status and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module eth_dma_status_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [12:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        pready,
    input wire logic        no_buffer_drop,
    input wire logic        fifo_overflow_drop,
    input wire logic        tx_desc_load,
    input wire logic [31:0] tx_desc_addr,
    input wire logic        rx_desc_load,
    input wire logic [31:0] rx_desc_addr,
    input wire logic        tx_buf_load,
    input wire logic [31:0] tx_buf_addr,
    input wire logic        rx_buf_load,
    input wire logic [31:0] rx_buf_addr
);
    // ==========================================
    // read decode and reference counts
    logic        known;
    logic        cap;
    logic        done;
    logic        cap_counts;
    logic        drops_since_q;
    logic [15:0] nb_q;
    logic [10:0] fo_q;
    logic        nb_wrap_q;
    logic        fo_wrap_q;
    logic [31:0] ptr_q [4];
    assign known = paddr inside {13'h1020, 13'h1048, 13'h104C, 13'h1050, 13'h1054,
                                 13'h1100, 13'h1104};
    // a read is captured in its wait cycle and shown while pready is high
    assign cap        = psel && penable && !pready && !pwrite;
    assign done       = psel && penable && pready;
    assign cap_counts = cap && (paddr == 13'h1020);
    // a drop in the capturing cycle counts after the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drops_since_q <= 1'b0;
            nb_q          <= 16'h0000;
            fo_q          <= 11'h000;
            nb_wrap_q     <= 1'b0;
            fo_wrap_q     <= 1'b0;
            ptr_q         <= '{default: 32'h0000_0000};
        end else begin
            drops_since_q <= (drops_since_q && !cap_counts)
                             || no_buffer_drop || fifo_overflow_drop;
            nb_q          <= (cap_counts ? 16'h0000 : nb_q) + 16'(no_buffer_drop);
            fo_q          <= (cap_counts ? 11'h000 : fo_q) + 11'(fifo_overflow_drop);
            nb_wrap_q     <= !cap_counts && (nb_wrap_q || (no_buffer_drop && (&nb_q)));
            fo_wrap_q     <= !cap_counts && (fo_wrap_q || (fifo_overflow_drop && (&fo_q)));
            if (tx_desc_load) ptr_q[0] <= tx_desc_addr;
            if (rx_desc_load) ptr_q[1] <= rx_desc_addr;
            if (tx_buf_load) ptr_q[2] <= tx_buf_addr;
            if (rx_buf_load) ptr_q[3] <= rx_buf_addr;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_unmapped_error: assert property (done && !known |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_read_wait: assert property (cap |=> pready)
        else $error("read not answered after one wait cycle");
    a_reserved_zero: assert property (cap_counts |=> prdata[31:29] == 3'h0)
        else $error("reserved counter bits set");
    a_count_clear: assert property (cap_counts && !drops_since_q |=> prdata == 32'h0)
        else $error("counts kept");
    a_nobuf_step: assert property (cap_counts |=> prdata[15:0] == $past(nb_q))
        else $error("no-buffer count wrong");
    a_nobuf_wrap: assert property (cap_counts |=> prdata[16] == $past(nb_wrap_q))
        else $error("no-buffer wrap flag wrong");
    a_fifo_step: assert property (cap_counts |=> prdata[27:17] == $past(fo_q))
        else $error("fifo count wrong");
    a_fifo_wrap: assert property (cap_counts |=> prdata[28] == $past(fo_wrap_q))
        else $error("fifo wrap flag wrong");
    a_txd_ptr: assert property (cap && paddr == 13'h1048 |=>
        prdata == $past(ptr_q[0])) else $error("tx descriptor pointer wrong");
    a_rxd_ptr: assert property (cap && paddr == 13'h104C |=>
        prdata == $past(ptr_q[1])) else $error("rx descriptor pointer wrong");
    a_txb_ptr: assert property (cap && paddr == 13'h1050 |=>
        prdata == $past(ptr_q[2])) else $error("tx buffer pointer wrong");
    a_rxb_ptr: assert property (cap && paddr == 13'h1054 |=>
        prdata == $past(ptr_q[3])) else $error("rx buffer pointer wrong");
endmodule
`default_nettype wire

// file: tb/dma_engine_model.sv
// model of the dma engine: drop strobes and pointer loads
// assumes its tasks are called just after a rising pclk edge
`timescale 1ns/1ns
`default_nettype none
module dma_engine_model (
    input  wire logic        pclk,
    output logic             no_buffer_drop,
    output logic             fifo_overflow_drop,
    output logic             tx_desc_load,
    output logic [31:0]      tx_desc_addr,
    output logic             rx_desc_load,
    output logic [31:0]      rx_desc_addr,
    output logic             tx_buf_load,
    output logic [31:0]      tx_buf_addr,
    output logic             rx_buf_load,
    output logic [31:0]      rx_buf_addr
);
    // ==========================================
    // strobes and pointers
    logic [3:0]  ld_q = 4'h0;
    logic [31:0] addr_q [4] = '{default: 32'h0};
    initial begin
        no_buffer_drop = 1'b0;
        fifo_overflow_drop = 1'b0;
    end
    assign {rx_buf_load, tx_buf_load, rx_desc_load, tx_desc_load} = ld_q;
    assign tx_desc_addr = addr_q[0];
    assign rx_desc_addr = addr_q[1];
    assign tx_buf_addr  = addr_q[2];
    assign rx_buf_addr  = addr_q[3];
    // one strobe a cycle; both kinds may overlap
    task automatic drops(input int nb, input int fo);
        for (int i = 0; i < nb || i < fo; i++) begin
            no_buffer_drop <= i < nb;
            fifo_overflow_drop <= i < fo;
            @(posedge pclk);
        end
        no_buffer_drop <= 1'b0;
        fifo_overflow_drop <= 1'b0;
        @(posedge pclk);
    endtask
    // address lines turn over once the load is gone, so stale values never match
    task automatic ptr(input int k, input logic [31:0] v);
        ld_q[k] <= 1'b1;
        addr_q[k] <= v;
        @(posedge pclk);
        ld_q[k] <= 1'b0;
        addr_q[k] <= ~v;
    endtask
endmodule
`default_nettype wire

// file: tb/eth_dma_status_bench.sv
// self-checking bench for the dma status register block
// assumes an apb slave that may add wait states, and the dma engine model
`timescale 1ns/1ns
`default_nettype none
module eth_dma_status_bench;
    // ==========================================
    // signals and helpers
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [12:0] paddr = 13'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdat, tx_desc_addr, rx_desc_addr, tx_buf_addr, rx_buf_addr;
    logic [3:0]  pstrb = 4'hF;
    logic        pready, pslverr, irq, rerr, no_buffer_drop, fifo_overflow_drop;
    logic        tx_desc_load, rx_desc_load, tx_buf_load, rx_buf_load;
    int          fails = 0, tests_run = 0;
    logic [12:0] offs [5] = '{13'h1020, 13'h1048, 13'h104C, 13'h1050, 13'h1054};
    always #50 pclk = ~pclk;
    eth_dma_status uut (.*);
    dma_engine_model dma (.*);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [12:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [12:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk($sformatf("read %h", a), exp, rdat);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #8_000_000;
        fails++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (offs[i]) rd(offs[i], 32'h0);
        apb(1'b0, 13'h1000, 32'h0);
        chk("pslverr", 32'h1, {31'h0, rerr});
        $display("test reset done");
        dma.drops(3, 5);
        rd(13'h1020, 32'h000A_0003);
        rd(13'h1020, 32'h0);
        fork
            dma.drops(2, 2);
            rd(13'h1020, 32'h0002_0001);
        join
        rd(13'h1020, 32'h0002_0001);
        $display("test counts done");
        chk("irq", 32'h0, {31'h0, irq});
        rd(13'h1100, 32'h3);
        apb(1'b1, 13'h1104, 32'h1);
        rd(13'h1104, 32'h1);
        dma.drops(0, 1);
        chk("irq", 32'h0, {31'h0, irq});
        dma.drops(1, 0);
        chk("irq", 32'h1, {31'h0, irq});
        rd(13'h1100, 32'h3);
        chk("irq", 32'h0, {31'h0, irq});
        rd(13'h1020, 32'h0002_0001);
        $display("test interrupt done");
        foreach (offs[i]) if (i > 0) begin
            dma.ptr(i - 1, 32'hA5C3_0000 + i);
            rd(offs[i], 32'hA5C3_0000 + i);
            apb(1'b1, offs[i], 32'hFFFF_FFFF);
            rd(offs[i], 32'hA5C3_0000 + i);
        end
        $display("test pointers done");
        dma.drops(65536, 2048);
        rd(13'h1100, 32'hF);
        rd(13'h1020, 32'h1001_0000);
        rd(13'h1020, 32'h0);
        $display("test wrap done");
        finish_test();
    end
endmodule
bind eth_dma_status eth_dma_status_monitor mon (.*);
`default_nettype wire
